// ---- hw/dpx_page_ext.sv ----
// data page extension: address translation, page registers, traps
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`include "dpx_defines.svh"
// What this block does
// - separate read and write page registers; reads use one, writes the other
// - crossings count only for paged start with pre or post modified indirect
// - a qualifying boundary crossing clears effective address bit 15 only at the range ends listed below
// - normal overflow increments the page and keeps bit 15 set
// - normal underflow decrements the page and keeps bit 15 set
// - offset, modulo, bit-reversed crossings keep page, set bit 15, wrap
// - overflow from last data page keeps page 0x1FF, clears bit 15
// - pre-increment read overflow 0x2FF goes to 0x300, bit 15 stays set
// - post-increment read overflow at 0x3FF keeps page, clears bit 15
// - read underflow at page 0x001 keeps page, clears bit 15
// - read underflow at 0x200 keeps page, clears bit 15
// - read underflow at 0x300 moves to 0x2FF, bit 15 stays set
// - with bit 15 cleared the access lands in base data space
// - paged access with page 0x000 raises address error trap
// - program space write check never traps: the 9-bit write page never reaches 0x200
module dpx_page_ext
    import dpx_pkg::*;
(
    input  wire logic         clk_sys,
    input  wire logic         srst,
    input  wire logic [7:0]   reg_addr,
    input  wire logic [15:0]  reg_wdata,
    input  wire logic         reg_wr,
    input  wire logic         reg_rd,
    output logic [15:0]       reg_rdata,
    input  wire logic         acc_valid,
    input  wire logic         acc_write,
    input  wire dpx_mode_type acc_mode,
    input  wire logic [15:0]  acc_ea_start,
    input  wire logic [15:0]  acc_ea_calc,
    input  wire dpx_xing_type acc_xing,
    output logic              bus_valid,
    output logic              bus_write,
    output logic              bus_paged,
    output logic [9:0]        bus_page,
    output logic [15:0]       bus_addr,
    output logic              addr_err_trap,
    output logic              irq
);
    typedef struct packed {
        logic [9:0]               read_page;
        logic [8:0]               write_page;
        logic [`DPX_ST_WIDTH-1:0] status;
        logic [`DPX_ST_WIDTH-1:0] mask;
        logic [15:0]              rdata;
        logic                     bvalid;
        logic                     bwrite;
        logic                     bpaged;
        logic [9:0]               bpage;
        logic [15:0]              baddr;
        logic                     trap;
        logic                     irq;
    } dpx_state_type;

    dpx_state_type s_q;
    dpx_state_type s_d;

    logic [9:0]  cur_page;
    logic        start_paged;
    logic        linear;
    dpx_xing_type xing_eff;
    logic [9:0]  page_next;
    logic        win_bit;
    logic        zero_err;
    logic        ps_err;

    function automatic logic is_linear_mode(input dpx_mode_type m);
        return m == DPX_MODE_PRE_MOD || m == DPX_MODE_POST_MOD;
    endfunction : is_linear_mode

    // page register chosen by direction
    always_comb begin
        cur_page = acc_write ? {1'b0, s_q.write_page} : s_q.read_page;
    end

    always_comb begin
        start_paged = acc_ea_start[`DPX_EA_WINDOW_BIT];
        linear      = start_paged && is_linear_mode(acc_mode);
        xing_eff    = start_paged ? acc_xing : DPX_XING_NONE;
    end

    dpx_page_step dpx_page_step_inst (
        .page      (cur_page),
        .xing      (xing_eff),
        .linear    (linear),
        .is_read   (!acc_write),
        .page_next (page_next),
        .win_bit   (win_bit)
    );

    dpx_trap_check dpx_trap_check_inst (
        .page          (cur_page),
        .paged         (acc_valid && start_paged),
        .is_write      (acc_write),
        .zero_page_err (zero_err),
        .ps_write_err  (ps_err)
    );

    always_comb begin
        logic [15:0]              ea;
        logic                     rd_status;
        logic [`DPX_ST_WIDTH-1:0] ev;
        ea        = acc_ea_calc;
        rd_status = reg_rd && reg_addr == `DPX_OFS_STATUS;
        ev        = '0;
        s_d       = s_q;
        s_d.rdata = 16'h0000;
        s_d.bvalid = 1'b0;
        s_d.trap   = 1'b0;

        if (reg_wr) begin
            unique case (reg_addr)
                `DPX_OFS_READ_PAGE:  s_d.read_page  = reg_wdata[9:0];
                `DPX_OFS_WRITE_PAGE: s_d.write_page = reg_wdata[8:0];
                `DPX_OFS_MASK:       s_d.mask = reg_wdata[`DPX_ST_WIDTH-1:0];
                default: ;
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                `DPX_OFS_READ_PAGE:  s_d.rdata = {6'h00, s_q.read_page};
                `DPX_OFS_WRITE_PAGE: s_d.rdata = {7'h00, s_q.write_page};
                `DPX_OFS_STATUS:     s_d.rdata = {14'h0000, s_q.status};
                `DPX_OFS_MASK:       s_d.rdata = {14'h0000, s_q.mask};
                default:             s_d.rdata = 16'h0000;
            endcase
        end

        if (acc_valid) begin
            if (!start_paged) begin
                s_d.bpaged = 1'b0;
                s_d.bpage  = 10'h000;
                s_d.baddr  = ea;
            end else begin
                if (xing_eff != DPX_XING_NONE && linear) begin
                    ea[`DPX_EA_WINDOW_BIT] = 1'b0;
                end
                ea[`DPX_EA_WINDOW_BIT] = win_bit;
                s_d.bpaged = win_bit;
                // base data space when window bit dropped
                s_d.bpage  = win_bit ? page_next : 10'h000;
                s_d.baddr  = ea;
                if (acc_write) begin
                    s_d.write_page = page_next[8:0];
                end else begin
                    s_d.read_page = page_next;
                end
            end
            s_d.bvalid = !(zero_err || ps_err);
            s_d.bwrite = acc_write;
            s_d.trap   = zero_err || ps_err;
            ev[`DPX_ST_ZERO_PAGE] = zero_err;
            ev[`DPX_ST_PS_WRITE]  = ps_err;
            // a trapped access must not move the page
            if (zero_err || ps_err) begin
                s_d.read_page  = s_q.read_page;
                s_d.write_page = s_q.write_page;
                if (reg_wr && reg_addr == `DPX_OFS_READ_PAGE) begin
                    s_d.read_page = reg_wdata[9:0];
                end
                if (reg_wr && reg_addr == `DPX_OFS_WRITE_PAGE) begin
                    s_d.write_page = reg_wdata[8:0];
                end
            end
        end

        // set wins over read clear
        s_d.status = (rd_status ? '0 : s_q.status) | ev;
        s_d.irq    = |(s_d.status & s_d.mask);
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s_q            <= '0;
            s_q.read_page  <= `DPX_RST_READ_PAGE;
            s_q.write_page <= `DPX_RST_WRITE_PAGE;
        end else begin
            s_q <= s_d;
        end
    end

    always_comb begin
        reg_rdata     = s_q.rdata;
        bus_valid     = s_q.bvalid;
        bus_write     = s_q.bwrite;
        bus_paged     = s_q.bpaged;
        bus_page      = s_q.bpage;
        bus_addr      = s_q.baddr;
        addr_err_trap = s_q.trap;
        irq           = s_q.irq;
    end
endmodule : dpx_page_ext

// ---- common/dpx_defines.svh ----
// register offsets, reset values and page boundary constants
`ifndef DPX_DEFINES_SVH
`define DPX_DEFINES_SVH
`define DPX_OFS_READ_PAGE   8'h32
`define DPX_OFS_WRITE_PAGE  8'h34
`define DPX_OFS_STATUS      8'h36
`define DPX_OFS_MASK        8'h38
`define DPX_RST_READ_PAGE   10'h001
`define DPX_RST_WRITE_PAGE  9'h001
`define DPX_PAGE_ZERO       10'h000
`define DPX_PAGE_EDS_FIRST  10'h001
`define DPX_PAGE_EDS_LAST   10'h1FF
`define DPX_PAGE_LSW_FIRST  10'h200
`define DPX_PAGE_LSW_LAST   10'h2FF
`define DPX_PAGE_MSB_FIRST  10'h300
`define DPX_PAGE_MSB_LAST   10'h3FF
`define DPX_EA_WINDOW_BIT   15
`define DPX_ST_ZERO_PAGE    0
`define DPX_ST_PS_WRITE     1
`define DPX_ST_WIDTH        2
`endif

// ---- common/dpx_pkg.sv ----
// types shared by the page extension block
package dpx_pkg;
    typedef enum logic [2:0] {
        DPX_MODE_DIRECT,
        DPX_MODE_PRE_MOD,
        DPX_MODE_POST_MOD,
        DPX_MODE_REG_OFFSET,
        DPX_MODE_MODULO,
        DPX_MODE_BIT_REV
    } dpx_mode_type;

    typedef enum logic [1:0] {
        DPX_XING_NONE,
        DPX_XING_OVER,
        DPX_XING_UNDER
    } dpx_xing_type;
endpackage : dpx_pkg

// ---- hw/dpx_page_step.sv ----
// next page and window bit after a page boundary crossing
`timescale 1ns/1ps
`include "dpx_defines.svh"
module dpx_page_step
    import dpx_pkg::*;
(
    input  wire logic [9:0]   page,
    input  wire dpx_xing_type xing,
    input  wire logic         linear,
    input  wire logic         is_read,
    output logic [9:0]        page_next,
    output logic              win_bit
);
    always_comb begin
        page_next = page;
        win_bit   = 1'b1;
        if (!linear || xing == DPX_XING_NONE) begin
            win_bit = 1'b1;
        end else if (xing == DPX_XING_OVER) begin
            if (page == `DPX_PAGE_EDS_LAST) begin
                win_bit = 1'b0;
            end else if (is_read && page == `DPX_PAGE_LSW_LAST) begin
                page_next = `DPX_PAGE_MSB_FIRST;
            end else if (is_read && page == `DPX_PAGE_MSB_LAST) begin
                win_bit = 1'b0;
            end else begin
                page_next = page + 10'h001;
            end
        end else begin
            if (is_read && page == `DPX_PAGE_EDS_FIRST) begin
                win_bit = 1'b0;
            end else if (is_read && page == `DPX_PAGE_LSW_FIRST) begin
                win_bit = 1'b0;
            end else if (is_read && page == `DPX_PAGE_MSB_FIRST) begin
                page_next = `DPX_PAGE_LSW_LAST;
            end else begin
                page_next = page - 10'h001;
            end
        end
    end
endmodule : dpx_page_step

// ---- hw/dpx_trap_check.sv ----
// address error detection for a paged access
`timescale 1ns/1ps
`include "dpx_defines.svh"
module dpx_trap_check (
    input  wire logic [9:0] page,
    input  wire logic       paged,
    input  wire logic       is_write,
    output logic            zero_page_err,
    output logic            ps_write_err
);
    always_comb begin
        zero_page_err = paged && page == `DPX_PAGE_ZERO;
        ps_write_err  = paged && is_write &&
                        page >= `DPX_PAGE_LSW_FIRST;
    end
endmodule : dpx_trap_check

// ---- verification/dpx_page_ext_sva.sv ----
// port checks for the page extension block
`timescale 1ns/1ps
module dpx_page_ext_sva
    import dpx_pkg::*;
(
    input wire logic         clk_sys,
    input wire logic         srst,
    input wire logic         acc_valid,
    input wire logic         acc_write,
    input wire dpx_mode_type acc_mode,
    input wire logic [15:0]  acc_ea_start,
    input wire logic [15:0]  acc_ea_calc,
    input wire dpx_xing_type acc_xing,
    input wire logic         bus_valid,
    input wire logic         bus_write,
    input wire logic         bus_paged,
    input wire logic [15:0]  bus_addr,
    input wire logic         addr_err_trap
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    a_trap_no_bus: assert property (addr_err_trap |-> !bus_valid)
        else $error("trapped access reached the bus");
    a_trap_cause: assert property (addr_err_trap |-> $past(acc_valid))
        else $error("trap without an access");
    a_bus_answer: assert property (acc_valid |=> bus_valid || addr_err_trap)
        else $error("access neither issued nor trapped");
    a_write_dir: assert property (acc_valid |=> bus_write == $past(acc_write))
        else $error("bus direction differs from request");
    a_base_direct: assert property (acc_valid && !acc_ea_start[15]
        |=> bus_valid && !bus_paged && bus_addr == $past(acc_ea_calc))
        else $error("base space access was translated");
    a_nonlin_wrap: assert property (acc_valid && acc_ea_start[15]
        && acc_xing != DPX_XING_NONE && acc_mode inside {DPX_MODE_REG_OFFSET,
        DPX_MODE_MODULO, DPX_MODE_BIT_REV} |=> !bus_valid || bus_addr[15])
        else $error("wrapping crossing left the window");
    a_clear_base: assert property (bus_valid && !bus_addr[15] |-> !bus_paged)
        else $error("base space access marked paged");
    a_no_xing_win: assert property (acc_valid && acc_ea_start[15]
        && acc_xing == DPX_XING_NONE |=> !bus_valid || bus_addr[15] && bus_paged)
        else $error("window access left window without crossing");
endmodule : dpx_page_ext_sva
bind dpx_page_ext dpx_page_ext_sva dpx_page_ext_sva_inst (.clk_sys, .srst,
    .acc_valid, .acc_write, .acc_mode, .acc_ea_start, .acc_ea_calc, .acc_xing,
    .bus_valid, .bus_write, .bus_paged, .bus_addr, .addr_err_trap);

// ---- verification/dpx_agen_model.sv ----
// address generator model, one access request per call
`timescale 1ns/1ps
module dpx_agen_model
    import dpx_pkg::*;
(
    input  wire logic    clk_sys,
    output logic         acc_valid,
    output logic         acc_write,
    output dpx_mode_type acc_mode,
    output logic [15:0]  acc_ea_start,
    output logic [15:0]  acc_ea_calc,
    output dpx_xing_type acc_xing
);
    initial begin
        acc_valid = 1'h0;
        acc_write = 1'h0;
        acc_mode = DPX_MODE_DIRECT;
        acc_ea_start = 16'h0000;
        acc_ea_calc = 16'h0000;
        acc_xing = DPX_XING_NONE;
    end
    task issue(input logic w, input dpx_mode_type m, input logic [15:0] s,
               input logic [15:0] c, input dpx_xing_type x);
        @(posedge clk_sys);
        acc_valid <= 1'h1;
        acc_write <= w;
        acc_mode <= m;
        acc_ea_start <= s;
        acc_ea_calc <= c;
        acc_xing <= x;
        @(posedge clk_sys);
        acc_valid <= 1'h0;
        // stale addresses must not look valid
        acc_ea_start <= ~s;
        acc_ea_calc <= ~c;
    endtask : issue
endmodule : dpx_agen_model

// ---- verification/dpx_page_ext_tb.sv ----
// self-checking bench for the page extension block
`timescale 1ns/1ps
`include "dpx_defines.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
    $display("ERROR %0t got %h want %h", $time, a, e); end end
module dpx_page_ext_tb
    import dpx_pkg::*;
;
    logic clk_sys = 1'h0, srst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, bus_addr;
    logic acc_valid, acc_write, bus_valid, bus_write, bus_paged;
    logic addr_err_trap, irq;
    logic [15:0] acc_ea_start, acc_ea_calc, d;
    logic [9:0] bus_page;
    dpx_mode_type acc_mode;
    dpx_xing_type acc_xing;
    int n_mismatch = 0, checks = 0;
    always #12.5 clk_sys = ~clk_sys;
    dpx_agen_model ag (.clk_sys(clk_sys), .acc_valid(acc_valid),
        .acc_write(acc_write), .acc_mode(acc_mode), .acc_xing(acc_xing),
        .acc_ea_start(acc_ea_start), .acc_ea_calc(acc_ea_calc));
    dpx_page_ext dpx_page_ext_inst (.clk_sys(clk_sys), .srst(srst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acc_valid(acc_valid),
        .acc_write(acc_write), .acc_mode(acc_mode), .acc_xing(acc_xing),
        .acc_ea_start(acc_ea_start), .acc_ea_calc(acc_ea_calc),
        .bus_valid(bus_valid), .bus_write(bus_write), .bus_paged(bus_paged),
        .bus_page(bus_page), .bus_addr(bus_addr), .irq(irq),
        .addr_err_trap(addr_err_trap));
    task wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'h1;
        @(posedge clk_sys);
        reg_wr <= 1'h0;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk_sys);
        reg_rd <= 1'h0;
        #1 d = reg_rdata;
    endtask : rd
    // page set, crossing access, then window bit and page read back
    task cx(input logic w, input dpx_mode_type m, input dpx_xing_type x,
            input logic [9:0] p, input logic [9:0] ep, input logic eb);
        logic [7:0] a;
        a = w ? `DPX_OFS_WRITE_PAGE : `DPX_OFS_READ_PAGE;
        wr(a, {6'h00, p});
        ag.issue(w, m, 16'h8FFE, 16'h0FFE, x);
        #1 `CHK(bus_addr[15], eb)
        `CHK(bus_paged, eb)
        `CHK(bus_addr, {eb, 15'h0FFE})
        `CHK(bus_page, eb ? ep : 10'h000)
        `CHK(bus_valid, 1'h1)
        `CHK(bus_write, w)
        rd(a);
        `CHK(d, {6'h00, ep})
    endtask : cx
    task t_reset;
        rd(`DPX_OFS_READ_PAGE);
        `CHK(d, 16'h0001)
        rd(`DPX_OFS_WRITE_PAGE);
        `CHK(d, 16'h0001)
        rd(8'h3A);
        `CHK(d, 16'h0000)
        $display("t_reset done");
    endtask : t_reset
    task t_bounds;
        cx(0, DPX_MODE_PRE_MOD, DPX_XING_OVER, 10'h010, 10'h011, 1);
        cx(0, DPX_MODE_POST_MOD, DPX_XING_UNDER, 10'h010, 10'h00F, 1);
        cx(1, DPX_MODE_PRE_MOD, DPX_XING_OVER, 10'h010, 10'h011, 1);
        // write-side move must leave the read page alone
        rd(`DPX_OFS_READ_PAGE);
        `CHK(d, 16'h000F)
        cx(0, DPX_MODE_REG_OFFSET, DPX_XING_OVER, 10'h010, 10'h010, 1);
        cx(0, DPX_MODE_MODULO, DPX_XING_UNDER, 10'h010, 10'h010, 1);
        cx(1, DPX_MODE_BIT_REV, DPX_XING_OVER, 10'h010, 10'h010, 1);
        cx(0, DPX_MODE_PRE_MOD, DPX_XING_OVER, 10'h1FF, 10'h1FF, 0);
        cx(1, DPX_MODE_POST_MOD, DPX_XING_OVER, 10'h1FF, 10'h1FF, 0);
        cx(0, DPX_MODE_PRE_MOD, DPX_XING_OVER, 10'h2FF, 10'h300, 1);
        cx(0, DPX_MODE_POST_MOD, DPX_XING_OVER, 10'h3FF, 10'h3FF, 0);
        cx(0, DPX_MODE_PRE_MOD, DPX_XING_UNDER, 10'h001, 10'h001, 0);
        cx(0, DPX_MODE_POST_MOD, DPX_XING_UNDER, 10'h200, 10'h200, 0);
        cx(0, DPX_MODE_PRE_MOD, DPX_XING_UNDER, 10'h300, 10'h2FF, 1);
        $display("t_bounds done");
    endtask : t_bounds
    task t_base;
        wr(`DPX_OFS_READ_PAGE, 16'h0123);
        ag.issue(0, DPX_MODE_PRE_MOD, 16'h1234, 16'h1236, DPX_XING_OVER);
        #1 `CHK(bus_addr, 16'h1236)
        `CHK(bus_paged, 1'h0)
        rd(`DPX_OFS_READ_PAGE);
        `CHK(d, 16'h0123)
        $display("t_base done");
    endtask : t_base
    task t_trap;
        wr(`DPX_OFS_READ_PAGE, 16'h0000);
        ag.issue(0, DPX_MODE_DIRECT, 16'h8000, 16'h8000, DPX_XING_NONE);
        #1 `CHK(addr_err_trap, 1'h1)
        `CHK(bus_valid, 1'h0)
        @(posedge clk_sys);
        #1 `CHK(irq, 1'h0)
        wr(`DPX_OFS_MASK, 16'h0001);
        #1 `CHK(irq, 1'h1)
        rd(`DPX_OFS_STATUS);
        `CHK(d, 16'h0001)
        @(posedge clk_sys);
        #1 `CHK(irq, 1'h0)
        // page zero through the write page traps as well
        wr(`DPX_OFS_WRITE_PAGE, 16'h0000);
        ag.issue(1, DPX_MODE_POST_MOD, 16'h8000, 16'h8002, DPX_XING_NONE);
        #1 `CHK(addr_err_trap, 1'h1)
        `CHK(bus_valid, 1'h0)
        rd(`DPX_OFS_WRITE_PAGE);
        `CHK(d, 16'h0000)
        $display("t_trap done");
    endtask : t_trap
    task conclude;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : conclude
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        conclude();
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        srst <= 1'h0;
        t_reset();
        t_bounds();
        t_base();
        t_trap();
        conclude();
    end
endmodule : dpx_page_ext_tb
